// *** ifd_decode.sv ***
// instruction field decoder, index modification and operand forming
//
// Function
// RULE1: opcode is instruction bits 23..18, selecting one of 57 operations; the code flags only 54 codes valid.
// RULE2: index selector is bits 17..15, picking the modifying index register.
// RULE3: selector 0 passes low 15 bits; 1..7 add that index register.
// RULE4: seven 15-bit index registers numbered 1 to 7.
// RULE5: selector zero reads as zero with no storage behind it.
// RULE6: modified instruction lives only in holding register; storage untouched.
// RULE7: repeat loads index 7 with that instruction's low 15 bits.
// RULE8: operand modifier is bits 14..12 in every instruction.
// RULE9: modifier picks whole word, a third, or bits 14..0.
// RULE10: modifiers 1,2,3 sign-extend the selected third from bit 7.
// RULE11: modifiers 5,6,7 zero-extend the selected third.
// RULE12: modifier 4 keeps bits 14..0, upper bits zero.
// RULE13: store with third modifiers replaces only that third from bits 7..0.
// RULE14: store with modifier 4 replaces bits 14..0, keeps 23..15.
// RULE15: modified 12-bit base address selects one of 4096 locations.
// RULE16: negatives are bitwise inverses of positives.
// RULE17: subtraction complements subtrahend then adds with the adder.
// RULE18: minus zero tests negative and nonzero.
// RULE19: logic ops and long shift may leave minus zero.
// RULE20: index addition is modulo 2**15, carry dropped.
// RULE21: index 7 decrements by one per repeated execution.
// RULE22: adder carry out of bit 23 wraps into bit 0.
module ifd_decode #(
    parameter int W = ifd_pkg::WORD_W
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    // instruction load from storage
    input  wire logic          instr_load_i,
    input  wire logic [W-1:0]  instr_word_i,
    // sequencer events
    input  wire logic          repeat_step_i,
    input  wire logic          index_write_i,
    input  wire logic [2:0]    index_sel_i,
    input  wire logic [14:0]   index_data_i,
    // operand path
    input  wire logic          operand_load_i,
    input  wire logic [W-1:0]  storage_word_i,
    input  wire logic          store_i,
    input  wire logic [W-1:0]  store_reg_i,
    // arithmetic path
    input  wire logic          arith_go_i,
    input  wire logic          arith_sub_i,
    input  wire logic [W-1:0]  arith_a_i,
    input  wire logic [W-1:0]  arith_b_i,
    // decoded fields
    output logic [5:0]         opcode_o,
    output logic [2:0]         index_field_o,
    output logic [2:0]         modifier_o,
    output logic [14:0]        mod_low_o,
    output logic [11:0]        operand_addr_o,
    output logic               op_valid_o,
    output logic               repeat_op_o,
    output logic               minus_zero_op_o,
    // operand results
    output logic [W-1:0]       operand_o,
    output logic [W-1:0]       store_word_o,
    // arithmetic results and the index seven repeat count copy
    output logic [W-1:0]       sum_o,
    output logic               sum_negative_o,
    output logic               sum_nonzero_o,
    output logic [14:0]        repeat_count_index_o
);
    logic [14:0] index_reg [1:7];
    logic [14:0] next_low;
    logic [2:0]  sel;
    logic [14:0] sel_val;
    logic [W:0]  raw_sum;
    logic [W-1:0] addend;
    logic [W-1:0] next_sum;

    // selector zero has no storage, always reads zero
    function automatic logic [14:0] idx_read(input logic [2:0] s,
                                             input logic [14:0] r1,
                                             input logic [14:0] r2,
                                             input logic [14:0] r3,
                                             input logic [14:0] r4,
                                             input logic [14:0] r5,
                                             input logic [14:0] r6,
                                             input logic [14:0] r7);
        case (s)
            3'h1:    idx_read = r1;
            3'h2:    idx_read = r2;
            3'h3:    idx_read = r3;
            3'h4:    idx_read = r4;
            3'h5:    idx_read = r5;
            3'h6:    idx_read = r6;
            3'h7:    idx_read = r7;
            default: idx_read = ifd_pkg::IDX_RESET; // RULE5
        endcase
    endfunction

    // opcodes that may leave all ones in the accumulator
    function automatic logic mz_op(input logic [5:0] op);
        case (op)
            ifd_pkg::OP_LOG_PRODUCT, ifd_pkg::OP_REPL_LOG_PROD,
            ifd_pkg::OP_SEL_COMPL, ifd_pkg::OP_REPL_SEL_COMPL,
            ifd_pkg::OP_SUBST_BITS, ifd_pkg::OP_REPL_SUBST,
            ifd_pkg::OP_LONG_SHIFT: mz_op = 1'b1; // RULE19
            default:                mz_op = 1'b0;
        endcase
    endfunction

    assign sel     = instr_word_i[ifd_pkg::SEL_HI:ifd_pkg::SEL_LO]; // RULE2
    assign sel_val = idx_read(sel, index_reg[1], index_reg[2],
                              index_reg[3], index_reg[4], index_reg[5],
                              index_reg[6], index_reg[7]);
    // 15-bit add drops the carry out of the top bit
    assign next_low = instr_word_i[ifd_pkg::LOW_W-1:0] + sel_val; // RULE3 RULE20

    // holding register copy only; the storage word is never written here
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            opcode_o       <= 6'h00;
            index_field_o  <= 3'h0;
            modifier_o     <= 3'h0;
            mod_low_o      <= 15'h0000;
            operand_addr_o <= 12'h000;
            op_valid_o     <= 1'b0;
            repeat_op_o    <= 1'b0;
            minus_zero_op_o <= 1'b0;
        end else if (instr_load_i) begin // RULE6
            opcode_o       <= instr_word_i[ifd_pkg::OP_HI:ifd_pkg::OP_LO]; // RULE1
            index_field_o  <= sel;
            modifier_o     <= next_low[ifd_pkg::MOD_HI:ifd_pkg::MOD_LO]; // RULE8
            mod_low_o      <= next_low;
            operand_addr_o <= next_low[ifd_pkg::ADDR_HI:0]; // RULE15
            // 64 codes exist, only 54 are flagged as assigned operations
            op_valid_o     <= (instr_word_i[ifd_pkg::OP_LO +: 3] != 3'h0)
                && (instr_word_i[ifd_pkg::OP_HI:ifd_pkg::OP_LO] != 6'h33)
                && (instr_word_i[ifd_pkg::OP_HI:ifd_pkg::OP_LO] != 6'h3F); // RULE1
            repeat_op_o    <= instr_word_i[ifd_pkg::OP_HI:ifd_pkg::OP_LO]
                              == ifd_pkg::OP_REPEAT;
            minus_zero_op_o <= mz_op(instr_word_i[ifd_pkg::OP_HI:ifd_pkg::OP_LO]);
        end
    end

    // index registers 1..6: plain writes from the sequencer
    generate
        for (genvar i = 1; i < 7; i++) begin : g_idx
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    index_reg[i] <= ifd_pkg::IDX_RESET; // RULE4
                end else if (index_write_i && index_sel_i == 3'(i)) begin
                    index_reg[i] <= index_data_i;
                end
            end
        end
    endgenerate

    // index 7 doubles as the repeat counter; repeat load has priority
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            index_reg[7] <= ifd_pkg::IDX_RESET;
        end else if (instr_load_i && instr_word_i[ifd_pkg::OP_HI:ifd_pkg::OP_LO]
                     == ifd_pkg::OP_REPEAT) begin
            index_reg[7] <= next_low; // RULE7
        end else if (repeat_step_i) begin
            index_reg[7] <= index_reg[7] - 15'h0001; // RULE21
        end else if (index_write_i && index_sel_i == ifd_pkg::IDX_REPEAT) begin
            index_reg[7] <= index_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            repeat_count_index_o <= ifd_pkg::IDX_RESET;
        end else begin
            repeat_count_index_o <= index_reg[7];
        end
    end

    // operand forming from the storage word
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            operand_o <= 24'h00_0000;
        end else if (operand_load_i) begin
            case (ifd_pkg::ifd_mod_e'(modifier_o)) // RULE9
                ifd_pkg::MOD_WORD:  operand_o <= storage_word_i;
                ifd_pkg::MOD_LO_S:  operand_o <= {{16{storage_word_i[7]}},
                                                  storage_word_i[7:0]}; // RULE10
                ifd_pkg::MOD_MID_S: operand_o <= {{16{storage_word_i[15]}},
                                                  storage_word_i[15:8]};
                ifd_pkg::MOD_HI_S:  operand_o <= {{16{storage_word_i[23]}},
                                                  storage_word_i[23:16]};
                ifd_pkg::MOD_LOW15: operand_o <= {9'h000,
                                                  storage_word_i[14:0]}; // RULE12
                ifd_pkg::MOD_LO_Z:  operand_o <= {16'h0000,
                                                  storage_word_i[7:0]}; // RULE11
                ifd_pkg::MOD_MID_Z: operand_o <= {16'h0000,
                                                  storage_word_i[15:8]};
                ifd_pkg::MOD_HI_Z:  operand_o <= {16'h0000,
                                                  storage_word_i[23:16]};
                default:            operand_o <= storage_word_i;
            endcase
        end
    end

    // store merge: only the addressed portion changes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            store_word_o <= 24'h00_0000;
        end else if (store_i) begin
            case (modifier_o)
                3'h1, 3'h5: store_word_o <= {storage_word_i[23:8],
                                             store_reg_i[7:0]}; // RULE13
                3'h2, 3'h6: store_word_o <= {storage_word_i[23:16],
                                             store_reg_i[7:0],
                                             storage_word_i[7:0]};
                3'h3, 3'h7: store_word_o <= {store_reg_i[7:0],
                                             storage_word_i[15:0]};
                3'h4:       store_word_o <= {storage_word_i[23:15],
                                             store_reg_i[14:0]}; // RULE14
                default:    store_word_o <= store_reg_i;
            endcase
        end
    end

    // one's complement adder; subtract inverts the subtrahend
    assign addend   = arith_sub_i ? ~arith_b_i : arith_b_i; // RULE16 RULE17
    assign raw_sum  = {1'b0, arith_a_i} + {1'b0, addend};
    assign next_sum = raw_sum[W-1:0] + {{(W-1){1'b0}}, raw_sum[W]}; // RULE22

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sum_o          <= 24'h00_0000;
            sum_negative_o <= 1'b0;
            sum_nonzero_o  <= 1'b0;
        end else if (arith_go_i) begin
            sum_o          <= next_sum;
            // all ones counts as negative and as nonzero
            sum_negative_o <= next_sum[W-1]; // RULE18
            sum_nonzero_o  <= |next_sum; // RULE18
        end
    end

    // all checks share the one clock and the reset
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    chk_index_zero_sel: assert property ( // RULE3
        instr_load_i && sel == 3'h0
        |=> mod_low_o == $past(instr_word_i[14:0]))
        else $error("selector zero modified the low field");

    chk_index_add: assert property ( // RULE20
        instr_load_i
        |=> mod_low_o == $past(instr_word_i[14:0] + sel_val))
        else $error("index sum wrong");

    chk_sel_field: assert property ( // RULE2
        instr_load_i
        |=> index_field_o == $past(instr_word_i[17:15]))
        else $error("index field wrong");

    chk_mod_field: assert property ( // RULE8
        instr_load_i
        |=> modifier_o == mod_low_o[14:12])
        else $error("modifier field wrong");

    chk_fields_hold: assert property ( // RULE6
        !instr_load_i
        |=> $stable(mod_low_o) && $stable(opcode_o))
        else $error("holding fields changed without a load");

    chk_repeat_load_b7: assert property ( // RULE7
        instr_load_i && instr_word_i[23:18] == ifd_pkg::OP_REPEAT
        |=> index_reg[7] == mod_low_o)
        else $error("repeat did not load index seven");

    chk_repeat_flag: assert property ( // RULE7
        instr_load_i
        |=> repeat_op_o == ($past(instr_word_i[23:18]) == 6'h07))
        else $error("repeat flag wrong");

    chk_idx7_hold: assert property ( // RULE7
        !instr_load_i && !repeat_step_i && !index_write_i
        |=> $stable(index_reg[7]))
        else $error("index seven changed with no event");

    chk_repeat_dec_b7: assert property ( // RULE21
        repeat_step_i && !instr_load_i
        |=> index_reg[7] == $past(index_reg[7]) - 15'h0001)
        else $error("repeat step did not decrement index seven");

    chk_idx_write: assert property ( // RULE4
        index_write_i && index_sel_i == 3'h1
        |=> index_reg[1] == $past(index_data_i))
        else $error("index one write lost");

    chk_invalid_op: assert property ( // RULE1
        instr_load_i && instr_word_i[20:18] == 3'h0
        |=> !op_valid_o)
        else $error("unassigned opcode flagged valid");

    chk_addr_field: assert property ( // RULE15
        instr_load_i |=> operand_addr_o == mod_low_o[11:0]
        && opcode_o == $past(instr_word_i[23:18]))
        else $error("address or opcode field wrong");

    chk_word_operand: assert property ( // RULE9
        operand_load_i && modifier_o == 3'h0
        |=> operand_o == $past(storage_word_i))
        else $error("whole word operand wrong");

    chk_sign_extend: assert property ( // RULE10
        operand_load_i && modifier_o == 3'h1
        |=> operand_o == {{16{$past(storage_word_i[7])}},
                          $past(storage_word_i[7:0])})
        else $error("sign extension of low third wrong");

    chk_hi_sign: assert property ( // RULE10
        operand_load_i && modifier_o == 3'h3
        |=> operand_o == {{16{$past(storage_word_i[23])}},
                          $past(storage_word_i[23:16])})
        else $error("sign extension of high third wrong");

    chk_zero_extend: assert property ( // RULE11
        operand_load_i && modifier_o[2] && modifier_o != 3'h4
        |=> operand_o[23:8] == 16'h0000)
        else $error("zero extension upper bits not clear");

    chk_hi_zero: assert property ( // RULE11
        operand_load_i && modifier_o == 3'h7
        |=> operand_o[7:0] == $past(storage_word_i[23:16]))
        else $error("high third not moved down");

    chk_low15_operand: assert property ( // RULE12
        operand_load_i && modifier_o == 3'h4
        |=> operand_o == {9'h000, $past(storage_word_i[14:0])})
        else $error("modifier four operand wrong");

    chk_low15_store: assert property ( // RULE14
        store_i && modifier_o == 3'h4
        |=> store_word_o[23:15] == $past(storage_word_i[23:15])
            && store_word_o[14:0] == $past(store_reg_i[14:0]))
        else $error("modifier four store merge wrong");

    chk_third_store: assert property ( // RULE13
        store_i && modifier_o == 3'h2
        |=> store_word_o[15:8] == $past(store_reg_i[7:0])
            && store_word_o[7:0] == $past(storage_word_i[7:0]))
        else $error("center third store merge wrong");

    chk_low_store: assert property ( // RULE13
        store_i && modifier_o == 3'h5
        |=> store_word_o == {$past(storage_word_i[23:8]),
                             $past(store_reg_i[7:0])})
        else $error("low third store merge wrong");

    chk_minus_zero: assert property ( // RULE18
        arith_go_i && next_sum == 24'hFF_FFFF
        |=> sum_negative_o && sum_nonzero_o)
        else $error("minus zero flags wrong");

    chk_sum_flags: assert property ( // RULE18
        arith_go_i
        |=> sum_negative_o == sum_o[23] && sum_nonzero_o == (|sum_o))
        else $error("sum flags disagree with the sum");

    chk_end_around: assert property ( // RULE22
        arith_go_i && !arith_sub_i && arith_a_i == 24'h00_0007
        && arith_b_i == 24'hFF_FFFA |=> sum_o == 24'h00_0002)
        else $error("end around carry lost");

    chk_sub_identity: assert property ( // RULE17
        arith_go_i && arith_sub_i && arith_a_i == arith_b_i
        |=> sum_o == 24'hFF_FFFF)
        else $error("x minus x is not all ones");
endmodule

// *** ifd_pkg.sv ***
// package: field layout, operand modifiers and opcodes for the decoder
package ifd_pkg;
    localparam int WORD_W   = 24;
    localparam int OP_HI    = 23;
    localparam int OP_LO    = 18;
    localparam int SEL_HI   = 17;
    localparam int SEL_LO   = 15;
    localparam int MOD_HI   = 14;
    localparam int MOD_LO   = 12;
    localparam int ADDR_HI  = 11;
    localparam int LOW_W    = 15;
    localparam int ADDR_W   = 12;
    localparam int NUM_OPS  = 57;
    localparam logic [14:0] IDX_RESET = 15'h0000;
    localparam logic [2:0]  IDX_REPEAT = 3'h7;
    // operation codes that the decoder reacts to
    localparam logic [5:0] OP_REPEAT        = 6'h07;
    localparam logic [5:0] OP_LONG_SHIFT    = 6'h0E;
    localparam logic [5:0] OP_LOG_PRODUCT   = 6'h28;
    localparam logic [5:0] OP_SEL_COMPL     = 6'h2A;
    localparam logic [5:0] OP_SUBST_BITS    = 6'h2B;
    localparam logic [5:0] OP_REPL_LOG_PROD = 6'h2C;
    localparam logic [5:0] OP_REPL_SEL_COMPL = 6'h2E;
    localparam logic [5:0] OP_REPL_SUBST    = 6'h2F;
    typedef enum logic [2:0] {
        MOD_WORD, MOD_LO_S, MOD_MID_S, MOD_HI_S,
        MOD_LOW15, MOD_LO_Z, MOD_MID_Z, MOD_HI_Z
    } ifd_mod_e;
endpackage

// *** ifd_core_store.sv ***
// core storage model: fetch and operand read ports, one write port
module ifd_core_store (
    // clock
    input  wire logic        clk_i,
    // preload write
    input  wire logic        wr_en_i,
    input  wire logic [11:0] wr_addr_i,
    input  wire logic [23:0] wr_data_i,
    // instruction fetch
    input  wire logic [11:0] fetch_addr_i,
    output logic      [23:0] fetch_word_o,
    // operand read
    input  wire logic [11:0] oper_addr_i,
    output logic      [23:0] oper_word_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] store_mem [4096];
    // only the write port alters a word, never a fetch
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            store_mem[wr_addr_i] <= wr_data_i;
        end
    end
    assign fetch_word_o = store_mem[fetch_addr_i];
    assign oper_word_o  = store_mem[oper_addr_i];
endmodule

// *** tb.sv ***
// self-checking bench for the instruction field decoder
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, arst_n_i, instr_load_i, repeat_step_i, index_write_i;
    logic        operand_load_i, store_i, arith_go_i, arith_sub_i, we;
    logic        op_valid_o, repeat_op_o, minus_zero_op_o;
    logic        sum_negative_o, sum_nonzero_o;
    logic [2:0]  index_sel_i, index_field_o, modifier_o;
    logic [5:0]  opcode_o;
    logic [11:0] operand_addr_o, pc, wa;
    logic [14:0] index_data_i, mod_low_o, repeat_count_index_o;
    logic [23:0] instr_word_i, storage_word_i, store_reg_i, wd;
    logic [23:0] arith_a_i, arith_b_i, operand_o, store_word_o, sum_o;
    int          err_total, num_checks;

    ifd_decode uut (.clk_i, .arst_n_i, .instr_load_i, .instr_word_i,
        .repeat_step_i, .index_write_i, .index_sel_i, .index_data_i,
        .operand_load_i, .storage_word_i, .store_i, .store_reg_i,
        .arith_go_i, .arith_sub_i, .arith_a_i, .arith_b_i, .opcode_o,
        .index_field_o, .modifier_o, .mod_low_o, .operand_addr_o,
        .op_valid_o, .repeat_op_o, .minus_zero_op_o, .operand_o,
        .store_word_o, .sum_o, .sum_negative_o, .sum_nonzero_o,
        .repeat_count_index_o);
    ifd_core_store mem (.clk_i, .wr_en_i(we), .wr_addr_i(wa),
        .wr_data_i(wd), .fetch_addr_i(pc), .fetch_word_o(instr_word_i),
        .oper_addr_i(operand_addr_o), .oper_word_o(storage_word_i));

    task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
            err_total++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // bus-like strobes: one cycle high, outputs read once settled
    task automatic poke(logic [11:0] a, logic [23:0] d);
        @(posedge clk_i); we <= 1'b1; wa <= a; wd <= d;
        @(posedge clk_i); we <= 1'b0;
    endtask
    task automatic fetch(logic [11:0] a);
        @(posedge clk_i); pc <= a; instr_load_i <= 1'b1;
        @(posedge clk_i); instr_load_i <= 1'b0; #1;
    endtask
    task automatic idx_wr(logic [2:0] s, logic [14:0] d);
        @(posedge clk_i); index_write_i <= 1'b1;
        index_sel_i <= s; index_data_i <= d;
        @(posedge clk_i); index_write_i <= 1'b0;
    endtask
    task automatic step();
        @(posedge clk_i); repeat_step_i <= 1'b1;
        @(posedge clk_i); repeat_step_i <= 1'b0;
    endtask
    task automatic arith(logic s, logic [23:0] a, logic [23:0] b);
        @(posedge clk_i); arith_go_i <= 1'b1; arith_sub_i <= s;
        arith_a_i <= a; arith_b_i <= b;
        @(posedge clk_i); arith_go_i <= 1'b0; #1;
    endtask
    function automatic logic [23:0] exp_op(logic [2:0] m, logic [23:0] w);
        logic [7:0] t;
        t = (m[1:0] == 2'h1) ? w[7:0] : (m[1:0] == 2'h2) ? w[15:8] : w[23:16];
        if (m == 3'h0) return w;
        if (m == 3'h4) return {9'h000, w[14:0]};
        if (m[2]) return {16'h0000, t};
        return {{16{t[7]}}, t};
    endfunction
    function automatic logic [23:0] exp_st(logic [2:0] m, logic [23:0] w,
                                           logic [23:0] r);
        if (m == 3'h0) return r;
        if (m == 3'h4) return {w[23:15], r[14:0]};
        if (m[1:0] == 2'h1) return {w[23:8], r[7:0]};
        if (m[1:0] == 2'h2) return {w[23:16], r[7:0], w[7:0]};
        return {r[7:0], w[15:0]};
    endfunction

    task automatic t_decode();
        logic [5:0]  c;
        logic [23:0] w;
        logic        v, mz;
        for (int i = 0; i < 64; i++) begin
            c = 6'(i);
            w = {c, 3'h0, 3'h0, 12'h05A5};
            v = c[2:0] != 3'h0 && c != 6'h33 && c != 6'h3F;
            mz = c inside {ifd_pkg::OP_LONG_SHIFT, ifd_pkg::OP_LOG_PRODUCT,
                ifd_pkg::OP_SEL_COMPL, ifd_pkg::OP_SUBST_BITS,
                ifd_pkg::OP_REPL_LOG_PROD, ifd_pkg::OP_REPL_SEL_COMPL,
                ifd_pkg::OP_REPL_SUBST};
            poke(12'h010, w);
            fetch(12'h010);
            chk("opcode", 24'(opcode_o), 24'(c));
            chk("valid", 24'(op_valid_o), 24'(v));
            chk("minus_zero_op", 24'(minus_zero_op_o), 24'(mz));
            chk("repeat", 24'(repeat_op_o), 24'(c == ifd_pkg::OP_REPEAT));
            chk("held", instr_word_i, w);
            chk("addr", 24'(operand_addr_o), 24'h05A5);
        end
    endtask
    task automatic t_index();
        logic [14:0] v, e;
        idx_wr(3'h0, 15'h5555);
        for (int s = 0; s < 8; s++) begin
            v = (s == 0) ? 15'h0000 : 15'h7000 + 15'(s) * 15'h0111;
            if (s != 0) idx_wr(3'(s), v);
            poke(12'h011, {6'h0B, 3'(s), 15'h1234});
            fetch(12'h011);
            e = 15'h1234 + v;
            chk("field", 24'(index_field_o), 24'(s));
            chk("low", 24'(mod_low_o), 24'(e));
            chk("modifier", 24'(modifier_o), 24'(e[14:12]));
            chk("addr", 24'(operand_addr_o), 24'(e[11:0]));
        end
    endtask
    task automatic t_repeat();
        poke(12'h012, {ifd_pkg::OP_REPEAT, 3'h0, 15'h0002});
        fetch(12'h012);
        repeat (2) @(posedge clk_i);
        #1 chk("count", 24'(repeat_count_index_o), 24'h0002);
        repeat (3) step();
        repeat (2) @(posedge clk_i);
        #1 chk("count", 24'(repeat_count_index_o), 24'h7FFF);
        poke(12'h013, {6'h0B, 3'h7, 15'h0001});
        fetch(12'h013);
        chk("low", 24'(mod_low_o), 24'h0000);
    endtask
    task automatic t_operand();
        logic [23:0] w;
        for (int k = 0; k < 16; k++) begin
            w = k[3] ? 24'h81_3CC2 : 24'h7E_C341;
            poke(12'h040, w);
            poke(12'h020, {6'h0C, 3'h0, k[2:0], 12'h0040});
            fetch(12'h020);
            @(posedge clk_i); operand_load_i <= 1'b1;
            @(posedge clk_i); operand_load_i <= 1'b0; #1;
            chk("operand", operand_o, exp_op(k[2:0], w));
            @(posedge clk_i); store_i <= 1'b1; store_reg_i <= 24'h5A_6996;
            @(posedge clk_i); store_i <= 1'b0; #1;
            chk("store", store_word_o, exp_st(k[2:0], w, 24'h5A_6996));
        end
    endtask
    task automatic t_arith();
        logic [23:0] av[7] = '{24'h00_0007, 24'h00_0003, 24'hFF_FFF8,
            24'h00_0007, 24'hFF_FFFD, 24'h00_0005, 24'h00_0000};
        logic [23:0] bv[7] = '{24'hFF_FFFA, 24'hFF_FFFB, 24'hFF_FFF9,
            24'hFF_FFFA, 24'h00_0005, 24'hFF_FFFA, 24'h00_0000};
        logic [23:0] ev[7] = '{24'h00_0002, 24'hFF_FFFE, 24'hFF_FFF2,
            24'h00_000C, 24'hFF_FFF8, 24'hFF_FFFF, 24'hFF_FFFF};
        logic [6:0]  sv = 7'h58;
        logic [23:0] e;
        for (int i = 0; i < 7; i++) begin
            arith(sv[i], av[i], bv[i]);
            e = ev[i];
            chk("sum", sum_o, e);
            chk("negative", 24'(sum_negative_o), 24'(e[23]));
            chk("nonzero", 24'(sum_nonzero_o), 24'(|e));
        end
    endtask

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // generous bound: the sequence needs about five hundred cycles
    initial begin
        #2_000_000;
        err_total++;
        end_sim();
    end
    initial begin
        {arst_n_i, instr_load_i, repeat_step_i, index_write_i} = 4'h0;
        {operand_load_i, store_i, arith_go_i, arith_sub_i, we} = 5'h00;
        {index_sel_i, index_data_i, pc, wa, wd} = '0;
        {store_reg_i, arith_a_i, arith_b_i} = '0;
        err_total = 0;
        num_checks = 0;
        repeat (5) @(posedge clk_i);
        #1 chk("reset", 24'(opcode_o), 24'h0000);
        chk("reset", 24'(repeat_count_index_o), 24'h0000);
        @(posedge clk_i); arst_n_i <= 1'b1;
        t_decode();
        t_index();
        t_repeat();
        t_operand();
        t_arith();
        end_sim();
    end
endmodule
